// ===== hw/dimming_host_pkg.sv
// Constants for the single wire dimming port host controller
package dimming_host_pkg;
    localparam int CLK_MHZ = 25;
    // Link timing, in nanoseconds as printed or chosen
    localparam int START_HOLD_NS = 2000;
    localparam int EOS_NS = 2000;
    localparam int DETECT_DELAY_NS = 100000;
    localparam int DETECT_LOW_NS = 260000;
    localparam int ACK_PULSE_NS = 512000;
    localparam int SHUTDOWN_NS = 2500000;
    localparam int START_HOLD_CYC = (START_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int EOS_CYC = (EOS_NS * CLK_MHZ + 999) / 1000;
    localparam int DETECT_DELAY_CYC = (DETECT_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int DETECT_LOW_CYC = (DETECT_LOW_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam int ACK_PULSE_CYC = (ACK_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int SHUTDOWN_CYC = (SHUTDOWN_NS * CLK_MHZ + 999) / 1000;
    // Register offsets (byte addresses)
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_CMD = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_TIMING = 4'hc;
    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_OD_BIT = 1;
    // Command register fields
    localparam int CMD_ACKREQ_BIT = 7;
    localparam int CMD_SUBHI_BIT = 6;
    localparam int CMD_SUBLO_BIT = 5;
    localparam int LEVEL_W = 5;
    // Status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_READY_BIT = 1;
    localparam int ST_ACKOK_BIT = 2;
    localparam int ST_ACKBAD_BIT = 3;
    localparam int ST_DONE_BIT = 4;
    // Reset values
    localparam logic [7:0] DEVICE_ADDR_RST = 8'h00; // Arbitrary value
    localparam logic [15:0] BIT_UNIT_RST = 16'h0019;
    localparam logic [15:0] ACK_DELAY_RST = 16'h0064;
    localparam logic [7:0] CMD_RST = 8'h1f;
    // Released line is sampled this many cycles after entering the sample state
    localparam int ACK_SAMPLE_CYC = 2;
endpackage : dimming_host_pkg

// ===== hw/dimming_host.sv
// Host controller for the single wire dimming port, Wishbone slave
`timescale 1ns/1ps
module dimming_host
    import dimming_host_pkg::*;
#(
    parameter int DETECT_DELAY_CYCLES = DETECT_DELAY_CYC,
    parameter int DETECT_LOW_CYCLES = DETECT_LOW_CYC,
    parameter int ACK_PULSE_CYCLES = ACK_PULSE_CYC,
    parameter int SHUTDOWN_CYCLES = SHUTDOWN_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic line_i,
    output logic line_o,
    output logic line_oe
);
    typedef enum logic [3:0] {
        ST_OFF, ST_WAKE, ST_DETLOW, ST_IDLE, ST_START, ST_LOW, ST_HIGH,
        ST_EOS, ST_ACKWAIT, ST_ACKSAMP, ST_ACKEND, ST_SHUT
    } state_t;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0] ctrl_r;
    logic [7:0] addr_r;
    logic [7:0] cmd_r;
    logic [15:0] unit_r;
    logic [15:0] ackdly_r;
    logic go_r;
    logic ack_ok_r;
    logic ack_bad_r;
    logic done_r;
    state_t state_r;
    logic [31:0] cnt_r;
    logic [15:0] shift_r;
    logic [4:0] bits_r;
    logic hit;
    logic wr;
    logic rd_go;
    logic bit_is_one;
    logic ready;
    logic busy;
    logic fin_ok;
    logic fin_bad;
    logic [31:0] status;

    assign hit = wb_cyc_i && wb_stb_i;
    assign wr = hit && wb_we_i && !wb_ack_o;
    assign ready = (state_r == ST_IDLE);
    assign busy = go_r || !(ready || state_r == ST_OFF);
    assign bit_is_one = shift_r[15];
    assign rd_go = wr && wb_adr_i == OFS_CMD && wb_sel_i[0] && ready && !go_r;

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= hit && !wb_ack_o;
        end
    end

    always_comb begin
        status = 32'h0;
        status[ST_BUSY_BIT] = busy;
        status[ST_READY_BIT] = ready;
        status[ST_ACKOK_BIT] = ack_ok_r;
        status[ST_ACKBAD_BIT] = ack_bad_r;
        status[ST_DONE_BIT] = done_r;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wb_dat_o <= 32'h0;
        end else if (hit && !wb_we_i && !wb_ack_o) begin
            unique case (wb_adr_i)
                OFS_CTRL: wb_dat_o <= {16'h0, addr_r, 6'h0, ctrl_r};
                OFS_CMD: wb_dat_o <= {24'h0, cmd_r};
                OFS_STATUS: wb_dat_o <= status;
                OFS_TIMING: wb_dat_o <= {ackdly_r, unit_r};
                default: wb_dat_o <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= 2'h0;
            addr_r <= DEVICE_ADDR_RST;
            unit_r <= BIT_UNIT_RST;
            ackdly_r <= ACK_DELAY_RST;
        end else if (wr && wb_adr_i == OFS_CTRL) begin
            if (wb_sel_i[0]) begin
                ctrl_r <= wb_dat_i[1:0];
            end
            if (wb_sel_i[1]) begin
                addr_r <= wb_dat_i[15:8];
            end
        end else if (wr && wb_adr_i == OFS_TIMING) begin
            if (wb_sel_i[1:0] == 2'h3 && wb_dat_i[15:0] != 16'h0) begin
                unit_r <= wb_dat_i[15:0];
            end
            if (wb_sel_i[3:2] == 2'h3 && wb_dat_i[31:16] != 16'h0) begin
                ackdly_r <= wb_dat_i[31:16];
            end
        end
    end

    // Command word: write starts a frame when the link is ready
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cmd_r <= CMD_RST;
            go_r <= 1'b0;
        end else if (rd_go) begin
            cmd_r <= wb_dat_i[7:0];
            cmd_r[CMD_SUBHI_BIT] <= 1'b0;
            cmd_r[CMD_SUBLO_BIT] <= 1'b0;
            cmd_r[CMD_ACKREQ_BIT] <= wb_dat_i[CMD_ACKREQ_BIT] && ctrl_r[CTRL_OD_BIT];
            go_r <= 1'b1;
        end else if (state_r == ST_START) begin
            go_r <= 1'b0;
        end
    end

    // Result flags, set wins over clear by status write
    assign fin_ok = state_r == ST_ACKSAMP && cnt_r == 32'h0 && !line_i;
    assign fin_bad = state_r == ST_ACKSAMP && cnt_r == 32'h0 && line_i;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ack_ok_r <= 1'b0;
            ack_bad_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            if (wr && wb_adr_i == OFS_STATUS && wb_sel_i[0]) begin
                ack_ok_r <= ack_ok_r && !wb_dat_i[ST_ACKOK_BIT];
                ack_bad_r <= ack_bad_r && !wb_dat_i[ST_ACKBAD_BIT];
                done_r <= done_r && !wb_dat_i[ST_DONE_BIT];
            end
            if (fin_ok) begin
                ack_ok_r <= 1'b1;
            end
            if (fin_bad) begin
                ack_bad_r <= 1'b1;
            end
            if (state_r == ST_ACKEND && cnt_r == 32'h0) begin
                done_r <= 1'b1;
            end else if (state_r == ST_EOS && cnt_r == 32'h0 && bits_r == 5'd16
                         && !cmd_r[CMD_ACKREQ_BIT]) begin
                done_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Link sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_OFF;
            cnt_r <= 32'h0;
            shift_r <= 16'h0;
            bits_r <= 5'h0;
        end else if (!ctrl_r[CTRL_EN_BIT] && state_r != ST_OFF && state_r != ST_SHUT) begin
            state_r <= ST_SHUT;
            cnt_r <= 32'(SHUTDOWN_CYCLES);
        end else begin
            if (cnt_r != 32'h0) begin
                cnt_r <= cnt_r - 32'h1;
            end
            unique case (state_r)
                ST_OFF: begin
                    if (ctrl_r[CTRL_EN_BIT]) begin
                        state_r <= ST_WAKE;
                        cnt_r <= 32'(DETECT_DELAY_CYCLES);
                    end
                end
                ST_WAKE: begin
                    if (cnt_r == 32'h0) begin
                        state_r <= ST_DETLOW;
                        cnt_r <= 32'(DETECT_LOW_CYCLES);
                    end
                end
                ST_DETLOW: begin
                    if (cnt_r == 32'h0) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (go_r) begin
                        state_r <= ST_START;
                        shift_r <= {addr_r, cmd_r};
                        bits_r <= 5'h0;
                        cnt_r <= 32'(START_HOLD_CYC);
                    end
                end
                ST_START: begin
                    if (cnt_r == 32'h0) begin
                        state_r <= ST_LOW;
                        cnt_r <= bit_is_one ? 32'(unit_r) : 32'({unit_r, 1'b0}) + 32'(unit_r);
                    end
                end
                ST_LOW: begin
                    if (cnt_r == 32'h0) begin
                        state_r <= ST_HIGH;
                        cnt_r <= bit_is_one ? 32'({unit_r, 1'b0}) + 32'(unit_r) : 32'(unit_r);
                    end
                end
                ST_HIGH: begin
                    if (cnt_r == 32'h0) begin
                        shift_r <= {shift_r[14:0], 1'b0};
                        bits_r <= bits_r + 5'h1;
                        if (bits_r == 5'd7 || bits_r == 5'd15) begin
                            state_r <= ST_EOS;
                            cnt_r <= 32'(EOS_CYC);
                        end else begin
                            state_r <= ST_LOW;
                            cnt_r <= shift_r[14] ? 32'(unit_r) : 32'({unit_r, 1'b0}) + 32'(unit_r);
                        end
                    end
                end
                ST_EOS: begin
                    if (cnt_r == 32'h0) begin
                        if (bits_r == 5'd8) begin
                            state_r <= ST_START;
                            cnt_r <= 32'(START_HOLD_CYC);
                        end else if (cmd_r[CMD_ACKREQ_BIT]) begin
                            state_r <= ST_ACKWAIT;
                            cnt_r <= 32'(ackdly_r);
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_ACKWAIT: begin
                    if (cnt_r == 32'h0) begin
                        state_r <= ST_ACKSAMP;
                        cnt_r <= 32'(ACK_SAMPLE_CYC);
                    end
                end
                ST_ACKSAMP: begin
                    if (cnt_r == 32'h0) begin
                        state_r <= ST_ACKEND;
                        cnt_r <= 32'(ACK_PULSE_CYCLES);
                    end
                end
                ST_ACKEND: begin
                    if (cnt_r == 32'h0 && line_i) begin
                        state_r <= ST_IDLE;
                    end else if (cnt_r == 32'h0) begin
                        cnt_r <= 32'h0;
                    end
                end
                ST_SHUT: begin
                    if (cnt_r == 32'h0) begin
                        state_r <= ST_OFF;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Line driver
    // ------------------------------------------------------------
    // Open drain drives only low; push-pull also drives high
    // End of stream is low so the last bit of each byte gets its closing falling edge
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            line_o <= 1'b0;
            line_oe <= 1'b1;
        end else begin
            unique case (state_r)
                ST_OFF, ST_SHUT, ST_DETLOW, ST_LOW, ST_EOS, ST_ACKWAIT: begin
                    line_o <= 1'b0;
                    line_oe <= 1'b1;
                end
                ST_ACKSAMP, ST_ACKEND: begin
                    line_o <= 1'b0;
                    line_oe <= 1'b0;
                end
                default: begin
                    line_o <= 1'b1;
                    line_oe <= !ctrl_r[CTRL_OD_BIT];
                end
            endcase
        end
    end
endmodule : dimming_host

// ===== verif/dimming_host_properties.sv
// Port checker for the dimming host controller
`timescale 1ns/1ps
module dimming_host_properties (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic line_i,
    input wire logic line_o,
    input wire logic line_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_hole_rd;
        s_req ##0 !wb_we_i && !(wb_adr_i inside {4'h0, 4'h4, 4'h8, 4'hc});
    endsequence
    a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_hole_zero: assert property (s_hole_rd |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_reset_off: assert property ($rose(resetn) |-> line_oe && !line_o)
        else $error("line not low after reset");
    a_no_clash: assert property (line_oe && line_o |-> line_i)
        else $error("host drives high against pull down");
    a_low_min: assert property ($fell(line_i) |=> !line_i [*7])
        else $error("low phase too short");
    a_high_min: assert property ($rose(line_i) |=> line_i [*7])
        else $error("high phase too short");
endmodule : dimming_host_properties

bind dimming_host dimming_host_properties u_props (.core_clk(core_clk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .line_i(line_i), .line_o(line_o),
    .line_oe(line_oe));

// ===== verif/dim_device_model.sv
// Behavioural model of the dimming port device on the control line
`timescale 1ns/1ps
module dim_device_model #(
    parameter logic [7:0] DEV_ADDR = 8'h5b, // Arbitrary value
    parameter int DET_LOW = 25,
    parameter int VAL_DLY = 60,
    parameter int ACK_LEN = 120,
    parameter int SHUT = 300,
    parameter int IDLE = 400
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic line,
    output logic pull_low,
    output logic [4:0] level_r,
    output logic mode_r
);
    logic prev_r, seen_r, go_r, done_r;
    logic [15:0] sh_r;
    int nb_r, lo_r, hi_r, lol_r, ak_r;
    assign pull_low = ak_r > VAL_DLY && ak_r <= VAL_DLY + ACK_LEN;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {prev_r, seen_r, go_r, done_r, mode_r, sh_r} <= '0;
            {nb_r, lo_r, hi_r, lol_r, ak_r} <= '0;
            level_r <= 5'h1f;
        end else begin
            prev_r <= line;
            hi_r <= line ? hi_r + 1 : 0;
            lo_r <= line ? 0 : lo_r + 1;
            if (line) seen_r <= 1'b1;
            if (line && !prev_r) lol_r <= lo_r;
            if (ak_r != 0) ak_r <= (ak_r == VAL_DLY + ACK_LEN) ? 0 : ak_r + 1;
            if (!mode_r && seen_r && lo_r == DET_LOW) mode_r <= 1'b1;
            if (lo_r == SHUT && ak_r == 0) begin
                {mode_r, seen_r, go_r} <= '0;
                level_r <= 5'h1f;
            end
            if (hi_r == IDLE) {go_r, nb_r} <= '0;
            if (mode_r && ak_r == 0 && !line && prev_r) begin
                if (!go_r) go_r <= 1'b1;
                else if (hi_r >= 2 * lol_r || lol_r >= 2 * hi_r) begin
                    sh_r <= {sh_r[14:0], hi_r >= 2 * lol_r};
                    nb_r <= nb_r + 1;
                    go_r <= nb_r % 8 != 7;
                    done_r <= nb_r == 15;
                end else {go_r, nb_r} <= '0;
            end
            if (done_r) begin
                {done_r, nb_r} <= '0;
                if (sh_r[15:8] == DEV_ADDR && sh_r[6:5] == 2'b00) level_r <= sh_r[4:0];
                if (sh_r[15:8] == DEV_ADDR && sh_r[7]) ak_r <= 1;
            end
        end
    end
endmodule : dim_device_model

// ===== verif/tb_dimming_host.sv
// Testbench for the dimming host controller
`timescale 1ns/1ps
module tb_dimming_host;
    logic core_clk, resetn, cyc, stb, we, ack, line_o, line_oe, pull_low, mode;
    logic [3:0] adr;
    logic [31:0] wdat, rdat, d;
    logic [4:0] lvl;
    logic [4:0] lv [3] = '{5'h15, 5'h0b, 5'h01};
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    wire line = ((line_oe && !line_o) || pull_low) ? 1'b0 : 1'b1;
    dimming_host #(.DETECT_DELAY_CYCLES(20), .DETECT_LOW_CYCLES(30),
        .ACK_PULSE_CYCLES(150), .SHUTDOWN_CYCLES(400)) dut (
        .core_clk(core_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .line_i(line), .line_o(line_o), .line_oe(line_oe));
    dim_device_model model (.core_clk(core_clk), .resetn(resetn), .line(line),
        .pull_low(pull_low), .level_r(lvl), .mode_r(mode));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= wd;
        do @(posedge core_clk); while (ack !== 1'b1);
        d = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : xfer
    task automatic poll(input int b);
        d = 32'h0;
        while (d[b] !== 1'b1) xfer(1'b0, 4'h8, 32'h0);
    endtask : poll
    task automatic send(input logic [4:0] l, input logic [31:0] st, input logic [4:0] el);
        poll(1);
        xfer(1'b1, 4'h4, {24'h0, 3'b100, l});
        poll(4);
        check(d & 32'hc, st);
        check({27'h0, lvl}, {27'h0, el});
        xfer(1'b1, 4'h8, 32'h1c);
        $display("test frame done");
    endtask : send
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            finish_test();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {resetn, cyc, stb, we, adr, wdat} = '0;
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        xfer(1'b0, 4'h4, 32'h0);
        check(d, 32'h1f);
        xfer(1'b0, 4'hc, 32'h0);
        check(d, 32'h00640019);
        xfer(1'b1, 4'h2, 32'hffff);
        xfer(1'b0, 4'h2, 32'h0);
        check(d, 32'h0);
        check({27'h0, lvl}, 32'h1f);
        $display("test reset done");
        xfer(1'b1, 4'h0, 32'h5b03);
        poll(1);
        check({31'h0, mode}, 32'h1);
        $display("test enable done");
        foreach (lv[i]) send(lv[i], 32'h4, lv[i]);
        xfer(1'b1, 4'h0, 32'h5c03);
        send(5'h03, 32'h8, 5'h01);
        xfer(1'b1, 4'h0, 32'h5b03);
        xfer(1'b1, 4'hc, 32'h0064000a);
        send(5'h11, 32'h4, 5'h11);
        xfer(1'b1, 4'h0, 32'h5b01);
        send(5'h07, 32'h0, 5'h07);
        xfer(1'b0, 4'h4, 32'h0);
        check(d, 32'h07);
        xfer(1'b1, 4'h0, 32'h0);
        repeat (500) @(posedge core_clk);
        check({27'h0, lvl}, 32'h1f);
        check({31'h0, mode}, 32'h0);
        $display("test shutdown done");
        finish_test();
    end
endmodule : tb_dimming_host
